// ==== logic/dsm_pkg.sv ====
// Summary of operation
// - four modes: sleep, normal, fail-safe, fault; independent channels
// - sleep if no wake; fault if fault; fail-safe if fail-safe; else normal
// - rising wake-reset pin or direct input puts the device in normal mode
// - normal-mode flag reads one while normal mode is active
// - wake-up resets registers; functions become available 50 us later
// - normal mode: direct input, internal clock or external clock control
// - target = in&dir field, or on&phase&pwm enable, or on&~pwm enable
// - duty value is bits 7..0 of the pulse-width register
// - direct input mode tracks the input level
// - internal clock mode: per-channel divider and duty
// - external clock mode: modulation period follows the external clock
// - watchdog bit must toggle within 310 ms unless watchdog disabled
// - direct input idle past 250 ms drops its activity flag
// - both activity flags low and wake pin low gives sleep
// - wake pin low or fail-safe: channels follow direct inputs only
// - fail-safe term is watchdog timeout or enabled logic supply loss
// - watchdog disable bit 4 of global config blocks timeout fail-safe
// - fault is OR of channel faults, undervoltage, gated overvoltage
// - watchdog runs in normal mode with logic supply, disable bit 0, wake pin 1
// - wake pin rising edge with logic supply starts the watchdog
// - watchdog watches the top bit of every received serial word
// - fail-safe exit: word with toggle bit 1, second word within timeout
// - fail-safe entry: indicator low, registers reset and locked
package dsm_pkg;
    // time base and timing
    localparam int unsigned CLK_PERIOD_NS     = 10;
    localparam int unsigned TICK_PERIOD_US    = 1000;
    localparam int unsigned TICK_CYCLES       =
        TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned WAKE_READY_US     = 50;
    localparam int unsigned WAKE_READY_CYCLES =
        (WAKE_READY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WDTO_MS           = 310;
    localparam int unsigned WDTO_TICKS        =
        WDTO_MS * 1000 / TICK_PERIOD_US;
    localparam int unsigned IN_TIMEOUT_MS     = 250;
    localparam int unsigned IN_TIMEOUT_TICKS  =
        IN_TIMEOUT_MS * 1000 / TICK_PERIOD_US;

    // register byte offsets
    localparam logic [7:0] CH0_PW_OFS  = 8'h00;
    localparam logic [7:0] CH1_PW_OFS  = 8'h04;
    localparam logic [7:0] GCR_OFS     = 8'h08;
    localparam logic [7:0] SERIAL_OFS  = 8'h0C;
    localparam logic [7:0] STATUS_OFS  = 8'h10;

    // pulse_width_register fields
    localparam int unsigned PW_DUTY_LSB    = 0;
    localparam int unsigned PW_ON_BIT      = 8;
    localparam int unsigned PW_PWM_EN_BIT  = 9;
    localparam int unsigned PW_DIR_BIT     = 10;
    localparam int unsigned PW_CLK_INT_BIT = 11;
    localparam int unsigned PW_DIV_LSB     = 12;
    localparam logic [15:0] PW_RST         = 16'h0000;

    // global_config_register fields
    localparam int unsigned GCR_FAIL_EN_BIT = 0;
    localparam int unsigned GCR_OV_GATE_BIT = 1;
    localparam int unsigned GCR_WATCHDOG_DISABLE_BIT  = 4;
    localparam logic [7:0]  GCR_RST         = 8'h02;

    // serial word field
    localparam int unsigned SER_WD_TOGGLE_BIT = 15;

    // global_status_register fields
    localparam int unsigned ST_MODE_LSB   = 0;
    localparam int unsigned ST_NORMAL_BIT = 2;
    localparam int unsigned ST_HSON_LSB   = 3;
    localparam int unsigned ST_INON_LSB   = 5;
    localparam int unsigned ST_WDTO_BIT   = 7;
    localparam int unsigned ST_READY_BIT  = 8;
    localparam int unsigned ST_SW_LSB     = 9;

    typedef enum logic [1:0] {
        DSM_SLEEP,
        DSM_NORMAL,
        DSM_FAILSAFE,
        DSM_FAULT
    } dsm_mode_e;
endpackage

// ==== logic/dsm_sync.sv ====
`timescale 1ns/1ps
module dsm_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         i_core_clk,
    input  wire logic         i_rst_n,
    // levels
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first stage feeds only the second
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule

// ==== logic/dsm_mode_ctrl.sv ====
`timescale 1ns/1ps
module dsm_mode_ctrl #(
    parameter int unsigned TICK_CYC = dsm_pkg::TICK_CYCLES,
    parameter int unsigned READY_CYC = dsm_pkg::WAKE_READY_CYCLES,
    parameter int unsigned WDTO_TK  = dsm_pkg::WDTO_TICKS,
    parameter int unsigned INTO_TK  = dsm_pkg::IN_TIMEOUT_TICKS
) (
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // host-side pins
    input  wire logic        i_wake_reset_pin,
    input  wire logic [1:0]  i_dir_in,
    input  wire logic        i_ext_pwm_clk,
    // supply and protection monitors
    input  wire logic        i_logic_supply_ok,
    input  wire logic [1:0]  i_overcurrent_fault,
    input  wire logic [1:0]  i_overtemperature_fault,
    input  wire logic [1:0]  i_severe_short_fault,
    input  wire logic        i_undervoltage_fault,
    input  wire logic        i_overvoltage_fault,
    // outputs
    output logic [1:0]       o_switch_output,
    output logic             o_failsafe_indicator_pin_oe_n,
    output logic             o_normal_mode_flag,
    output logic [1:0]       o_mode
);
    localparam int unsigned TW = $clog2(TICK_CYC + 1);
    localparam int unsigned RW = $clog2(READY_CYC + 1);
    localparam int unsigned WW = $clog2(WDTO_TK + 1);
    localparam int unsigned IW = $clog2(INTO_TK + 1);

    typedef struct packed {
        logic [TW-1:0]       tick_cnt;
        logic [RW-1:0]       ready_cnt;
        logic                ready;
        logic [WW-1:0]       wd_cnt;
        logic                wd_last;
        logic                wd_to;
        logic                exit_armed;
        logic                vdd_seen;
        logic                vdd_fs;
        logic [1:0][IW-1:0]  in_cnt;
        logic [1:0]          in_on;
        logic                wake_prev;
        logic                ext_prev;
        logic [1:0][15:0]    pw;
        logic [7:0]          global_config_register;
        logic [1:0][11:0]    div_cnt;
        logic [1:0][7:0]     pwm_cnt;
        dsm_pkg::dsm_mode_e  mode;
        logic                nm;
        logic [1:0]          sw;
        logic                fs_oe_n;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
    } dsm_state_s;

    dsm_state_s q;
    dsm_state_s d;

    logic [12:0] s;
    logic        wake_pin;
    logic [1:0]  dir_in;
    logic        ext_clk;
    logic        supply_ok;
    logic        fault_term;

    dsm_sync #(
        .W (13)
    ) u_sync (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_async    ({i_wake_reset_pin, i_dir_in, i_ext_pwm_clk,
                      i_logic_supply_ok, i_overcurrent_fault,
                      i_overtemperature_fault, i_severe_short_fault,
                      i_undervoltage_fault, i_overvoltage_fault}),
        .o_sync     (s)
    );

    assign wake_pin  = s[12];
    assign dir_in    = s[11:10];
    assign ext_clk   = s[9];
    assign supply_ok = s[8];
    assign fault_term = (|s[7:6]) | (|s[5:4]) | (|s[3:2]) | s[1]
                      | (s[0] & q.global_config_register[dsm_pkg::GCR_OV_GATE_BIT]);

    // target on state of one channel
    function automatic logic calc_hson(input logic [15:0] pw,
                                       input logic        din,
                                       input logic        phase,
                                       input logic        direct);
        logic on_bit;
        logic pwm_en;
        on_bit = pw[dsm_pkg::PW_ON_BIT];
        pwm_en = pw[dsm_pkg::PW_PWM_EN_BIT];
        if (direct) begin
            calc_hson = din;
        end else begin
            calc_hson = (din & pw[dsm_pkg::PW_DIR_BIT])
                      | (on_bit & phase & pwm_en)
                      | (on_bit & ~pwm_en);
        end
    endfunction

    // register address decode for reads and writes, unmapped answers with an error
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == dsm_pkg::CH0_PW_OFS) || (a == dsm_pkg::CH1_PW_OFS)
                 || (a == dsm_pkg::GCR_OFS) || (a == dsm_pkg::SERIAL_OFS)
                 || (a == dsm_pkg::STATUS_OFS);
    endfunction

    always_comb begin
        logic       tick;
        logic       wake;
        logic       wake_rise;
        logic       ext_rise;
        logic       acc;
        logic       ser_wr;
        logic       ser_bit;
        logic       cfg_wr;
        logic       fs_term;
        logic       direct;
        logic       step;
        logic       phase;
        logic       awake_op;
        logic [1:0] hson;
        tick      = 1'b0;
        wake      = 1'b0;
        wake_rise = 1'b0;
        ext_rise  = 1'b0;
        acc       = 1'b0;
        ser_wr    = 1'b0;
        ser_bit   = 1'b0;
        cfg_wr    = 1'b0;
        fs_term   = 1'b0;
        direct    = 1'b0;
        step      = 1'b0;
        phase     = 1'b0;
        awake_op  = 1'b0;
        hson      = 2'b00;
        d         = q;

        tick = (q.tick_cnt == TW'(TICK_CYC - 1));
        d.tick_cnt = tick ? '0 : TW'(q.tick_cnt + 1'b1);

        wake_rise   = wake_pin & ~q.wake_prev;
        ext_rise    = ext_clk & ~q.ext_prev;
        d.wake_prev = wake_pin;
        d.ext_prev  = ext_clk;

        for (int ch = 0; ch < 2; ch++) begin
            if (dir_in[ch]) begin
                d.in_on[ch]  = 1'b1;
                d.in_cnt[ch] = '0;
            end else if (tick && q.in_on[ch]) begin
                if (q.in_cnt[ch] == IW'(INTO_TK - 1)) begin
                    d.in_on[ch] = 1'b0;
                end else begin
                    d.in_cnt[ch] = IW'(q.in_cnt[ch] + 1'b1);
                end
            end
        end

        // sleep when all three are low
        wake = wake_pin | (|q.in_on);

        // apb: write takes effect at the answered access edge, read data is captured one edge earlier
        acc     = i_psel & i_penable & q.pready;
        ser_wr  = acc & i_pwrite & wake_pin
                & (i_paddr == dsm_pkg::SERIAL_OFS);
        ser_bit = i_pwdata[dsm_pkg::SER_WD_TOGGLE_BIT];
        cfg_wr  = acc & i_pwrite & wake_pin
                & (q.mode == dsm_pkg::DSM_NORMAL);

        // logic supply loss term, only once it was present
        if (supply_ok) begin
            d.vdd_seen = 1'b1;
        end

        // watch the top bit of every received word
        if (ser_wr) begin
            d.wd_last = ser_bit;
        end
        if (q.mode == dsm_pkg::DSM_FAILSAFE && ser_wr) begin
            if (q.exit_armed) begin
                d.exit_armed = 1'b0;
                d.wd_to      = 1'b0;
                d.vdd_fs     = 1'b0;
                d.wd_cnt     = '0;
            end else if (ser_bit) begin
                d.exit_armed = 1'b1;
                d.wd_cnt     = '0;
            end
        end else if (q.exit_armed && tick) begin
            if (q.wd_cnt == WW'(WDTO_TK - 1)) begin
                d.exit_armed = 1'b0;
            end else begin
                d.wd_cnt = WW'(q.wd_cnt + 1'b1);
            end
        // pin rising edge restarts the watchdog
        end else if (wake_rise && supply_ok) begin
            d.wd_cnt = '0;
        end else if (ser_wr && ser_bit != q.wd_last) begin
            d.wd_cnt = '0;
        // watchdog runs only under these conditions
        end else if (tick && supply_ok && wake_pin
                     && !q.global_config_register[dsm_pkg::GCR_WATCHDOG_DISABLE_BIT]
                     && q.mode == dsm_pkg::DSM_NORMAL && !q.wd_to) begin
            if (q.wd_cnt == WW'(WDTO_TK - 1)) begin
                d.wd_to = 1'b1;
            end else begin
                d.wd_cnt = WW'(q.wd_cnt + 1'b1);
            end
        end
        // loss event wins over a same-cycle exit
        if (q.global_config_register[dsm_pkg::GCR_FAIL_EN_BIT] && q.vdd_seen && !supply_ok) begin
            d.vdd_fs = 1'b1;
        end

        fs_term = (q.wd_to & ~q.global_config_register[dsm_pkg::GCR_WATCHDOG_DISABLE_BIT]) | q.vdd_fs;

        if (!wake) begin
            d.mode = dsm_pkg::DSM_SLEEP;
        end else if (fault_term) begin
            d.mode = dsm_pkg::DSM_FAULT;
        end else if (fs_term) begin
            d.mode = dsm_pkg::DSM_FAILSAFE;
        end else begin
            d.mode = dsm_pkg::DSM_NORMAL;
        end
        d.nm = (d.mode == dsm_pkg::DSM_NORMAL);

        // register writes
        if (cfg_wr && i_paddr == dsm_pkg::CH0_PW_OFS) begin
            d.pw[0] = i_pwdata[15:0];
        end
        if (cfg_wr && i_paddr == dsm_pkg::CH1_PW_OFS) begin
            d.pw[1] = i_pwdata[15:0];
        end
        if (cfg_wr && i_paddr == dsm_pkg::GCR_OFS) begin
            d.global_config_register = i_pwdata[7:0];
        end

        // wake from sleep resets registers and restarts the ready wait
        if (q.mode == dsm_pkg::DSM_SLEEP && d.mode != dsm_pkg::DSM_SLEEP) begin
            d.pw        = {2{dsm_pkg::PW_RST}};
            d.global_config_register       = dsm_pkg::GCR_RST;
            d.ready     = 1'b0;
            d.ready_cnt = '0;
        end else if (!q.ready) begin
            if (q.ready_cnt == RW'(READY_CYC - 1)) begin
                d.ready = 1'b1;
            end else begin
                d.ready_cnt = RW'(q.ready_cnt + 1'b1);
            end
        end
        if (d.mode == dsm_pkg::DSM_FAILSAFE
            && q.mode != dsm_pkg::DSM_FAILSAFE) begin
            d.pw  = {2{dsm_pkg::PW_RST}};
            d.global_config_register = dsm_pkg::GCR_RST;
        end
        // register contents held at defaults while the pin is low
        if (!wake_pin) begin
            d.pw  = {2{dsm_pkg::PW_RST}};
            d.global_config_register = dsm_pkg::GCR_RST;
        end

        // pin low or fail-safe means direct control
        direct   = ~wake_pin | (q.mode == dsm_pkg::DSM_FAILSAFE);
        awake_op = (q.mode == dsm_pkg::DSM_NORMAL)
                 | (q.mode == dsm_pkg::DSM_FAILSAFE);

        for (int ch = 0; ch < 2; ch++) begin
            // per-channel divider sets the step rate
            step = (q.div_cnt[ch] == '0);
            d.div_cnt[ch] = step ? {q.pw[ch][dsm_pkg::PW_DIV_LSB +: 4], 8'hFF}
                                 : 12'(q.div_cnt[ch] - 1'b1);
            if (q.pw[ch][dsm_pkg::PW_CLK_INT_BIT]) begin
                if (step) begin
                    d.pwm_cnt[ch] = 8'(q.pwm_cnt[ch] + 1'b1);
                end
            end else if (ext_rise) begin
                d.pwm_cnt[ch] = 8'h00;
            end else if (step && q.pwm_cnt[ch] != 8'hFF) begin
                d.pwm_cnt[ch] = 8'(q.pwm_cnt[ch] + 1'b1);
            end
            phase = q.pwm_cnt[ch] < q.pw[ch][dsm_pkg::PW_DUTY_LSB +: 8];
            // direct mode tracks the input level
            hson[ch] = calc_hson(q.pw[ch], dir_in[ch], phase, direct);
            d.sw[ch] = hson[ch] & awake_op & q.ready;
        end

        // indicator pulled low while fail-safe holds
        d.fs_oe_n = ~(fs_term & wake);

        // apb answer one cycle into the access phase
        d.pready  = i_psel & i_penable & ~q.pready;
        d.pslverr = 1'b0;
        d.prdata  = '0;
        if (i_psel && i_penable && !q.pready) begin
            d.pslverr = ~is_mapped(i_paddr);
            if (!i_pwrite) begin
                unique case (i_paddr)
                    dsm_pkg::CH0_PW_OFS: d.prdata = {16'h0000, q.pw[0]};
                    dsm_pkg::CH1_PW_OFS: d.prdata = {16'h0000, q.pw[1]};
                    dsm_pkg::GCR_OFS:    d.prdata = {24'h000000, q.global_config_register};
                    dsm_pkg::SERIAL_OFS:
                        d.prdata = {16'h0000, q.wd_last, 15'h0000};
                    dsm_pkg::STATUS_OFS:
                        d.prdata = {21'h000000, q.sw, q.ready, q.wd_to,
                                    q.in_on, hson,
                                    q.mode == dsm_pkg::DSM_NORMAL, q.mode};
                    default: d.prdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q         <= '0;
            q.mode    <= dsm_pkg::DSM_SLEEP;
            q.pw      <= {2{dsm_pkg::PW_RST}};
            q.global_config_register     <= dsm_pkg::GCR_RST;
            q.fs_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign o_prdata                      = q.prdata;
    assign o_pready                      = q.pready;
    assign o_pslverr                     = q.pslverr;
    assign o_switch_output               = q.sw;
    assign o_failsafe_indicator_pin_oe_n = q.fs_oe_n;
    // flag from its own register, loaded with the next-mode compare
    assign o_normal_mode_flag = q.nm;
    assign o_mode             = q.mode;
endmodule

// ==== test/dsm_mode_ctrl_props.sv ====
`timescale 1ns/1ps
module dsm_mode_ctrl_props (
    // clock and reset
    input wire logic       i_core_clk,
    input wire logic       i_rst_n,
    // watched inputs
    input wire logic       i_psel,
    input wire logic       i_penable,
    input wire logic       i_wake_reset_pin,
    input wire logic [1:0] i_overcurrent_fault,
    input wire logic [1:0] i_overtemperature_fault,
    input wire logic [1:0] i_severe_short_fault,
    input wire logic       i_undervoltage_fault,
    // watched outputs
    input wire logic       o_pready,
    input wire logic       o_pslverr,
    input wire logic [1:0] o_switch_output,
    input wire logic       o_failsafe_indicator_pin_oe_n,
    input wire logic       o_normal_mode_flag,
    input wire logic [1:0] o_mode
);
    logic flt;
    assign flt = |{i_overcurrent_fault, i_overtemperature_fault,
                   i_severe_short_fault, i_undervoltage_fault};
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_setup; i_psel && !i_penable; endsequence
    sequence s_access; i_psel && i_penable; endsequence
    sequence s_fault_held; (i_wake_reset_pin && flt)[*4]; endsequence
    property p_flag;
        o_normal_mode_flag == (o_mode == dsm_pkg::DSM_NORMAL);
    endproperty
    property p_fault; s_fault_held |-> ##1 o_mode == dsm_pkg::DSM_FAULT;
    endproperty
    property p_awake;
        i_wake_reset_pin[*4] |-> ##1 o_mode != dsm_pkg::DSM_SLEEP;
    endproperty
    property p_sw_gate;
        o_switch_output != 2'h0 |-> o_mode inside {dsm_pkg::DSM_NORMAL,
            dsm_pkg::DSM_FAILSAFE} || $past(o_mode) inside
            {dsm_pkg::DSM_NORMAL, dsm_pkg::DSM_FAILSAFE};
    endproperty
    property p_fault_off;
        (o_mode == dsm_pkg::DSM_FAULT)[*2] |-> o_switch_output == 2'h0;
    endproperty
    property p_fs_low;
        (o_mode == dsm_pkg::DSM_FAILSAFE)[*2] |->
            !o_failsafe_indicator_pin_oe_n;
    endproperty
    property p_nm_high;
        (o_mode == dsm_pkg::DSM_NORMAL)[*2] |-> o_failsafe_indicator_pin_oe_n;
    endproperty
    property p_answer; s_setup ##1 s_access |=> o_pready; endproperty
    property p_pulse; o_pready |=> !o_pready; endproperty
    property p_err; o_pslverr |-> o_pready; endproperty
    a_flag: assert property (p_flag)
        else $error("normal flag disagrees with mode");
    a_fault: assert property (p_fault)
        else $error("fault input did not give fault mode");
    a_awake: assert property (p_awake)
        else $error("sleep while wake pin high");
    a_sw_gate: assert property (p_sw_gate)
        else $error("switch on outside normal or fail-safe");
    a_fault_off: assert property (p_fault_off)
        else $error("switch on in fault mode");
    a_fs_low: assert property (p_fs_low)
        else $error("indicator released in fail-safe");
    a_nm_high: assert property (p_nm_high)
        else $error("indicator driven in normal mode");
    a_answer: assert property (p_answer)
        else $error("bus answer late");
    a_pulse: assert property (p_pulse)
        else $error("ready longer than one cycle");
    a_err: assert property (p_err)
        else $error("error without ready");
endmodule

// ==== test/dsm_host_model.sv ====
`timescale 1ns/1ps
module dsm_host_model (
    // clock
    input  wire logic i_core_clk,
    // host controls
    input  wire logic i_wake_req,
    input  wire logic i_supply_ok,
    input  wire logic i_ext_run,
    // pins
    output logic      o_wake_pin,
    output logic      o_ext_clk
);
    initial o_wake_pin = 1'b0;
    always @(posedge i_core_clk)
        o_wake_pin <= i_wake_req && (o_wake_pin || i_supply_ok);
    initial begin
        o_ext_clk = 1'b0;
        #37;
        forever begin
            #80;
            o_ext_clk = i_ext_run ? ~o_ext_clk : 1'b0;
        end
    end
endmodule

// ==== test/tb_dual_switch_mode_controller.sv ====
`timescale 1ns/1ps
module tb_dual_switch_mode_controller;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        wake_req, wake_pin, ext_run, ext_clk, supply_ok;
    logic        fs_oe_n, nm_flag;
    logic [1:0]  dir_in, sw, mode;
    logic [7:0]  flt;
    int          n_mismatch, checks;
    dsm_host_model host (.i_core_clk(clk), .i_wake_req(wake_req),
        .i_supply_ok(supply_ok), .i_ext_run(ext_run),
        .o_wake_pin(wake_pin), .o_ext_clk(ext_clk));
    dsm_mode_ctrl #(.TICK_CYC(10), .READY_CYC(20), .WDTO_TK(5),
        .INTO_TK(4)) dut (.i_core_clk(clk), .i_rst_n(rst_n),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr),
        .i_wake_reset_pin(wake_pin), .i_dir_in(dir_in),
        .i_ext_pwm_clk(ext_clk), .i_logic_supply_ok(supply_ok),
        .i_overcurrent_fault(flt[1:0]), .i_overtemperature_fault(flt[3:2]),
        .i_severe_short_fault(flt[5:4]), .i_undervoltage_fault(flt[6]),
        .i_overvoltage_fault(flt[7]), .o_switch_output(sw),
        .o_failsafe_indicator_pin_oe_n(fs_oe_n),
        .o_normal_mode_flag(nm_flag), .o_mode(mode));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic complete_run;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_pin(input logic [1:0] got, input logic [1:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t pins %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        cmp_reg(r, x);
        cmp_pin({1'b0, e}, {1'b0, xe});
    endtask
    task automatic wait_mode(input logic [1:0] m, input int lim);
        int n;
        n = 0;
        while (mode !== m && n < lim) begin
            @(posedge clk);
            n++;
        end
        cmp_pin(mode, m);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, wake_req, ext_run} = '0;
        {dir_in, flt, n_mismatch, checks} = '0;
        supply_ok = 1'b1;
        rst_n = 1'b0;
        cyc(12);
        rst_n <= 1'b1;
        cyc(2);
        cmp_pin(mode, dsm_pkg::DSM_SLEEP);
        rd(dsm_pkg::GCR_OFS, 32'h02, 1'b0);
        rd(8'h14, 32'h0, 1'b1);
        wake_req <= 1'b1;
        wait_mode(dsm_pkg::DSM_NORMAL, 10);
        cmp_pin({1'b0, nm_flag}, 2'h1);
        rd(dsm_pkg::STATUS_OFS, 32'h005, 1'b0);
        for (int i = 0; i < 4; i++) begin
            wr(dsm_pkg::SERIAL_OFS, i[0] ? 32'h0 : 32'h8000);
            cyc(30);
        end
        rd(dsm_pkg::STATUS_OFS, 32'h105, 1'b0);
        cmp_pin(mode, dsm_pkg::DSM_NORMAL);
        wait_mode(dsm_pkg::DSM_FAILSAFE, 60);
        cmp_pin({1'b0, fs_oe_n}, 2'h0);
        wr(dsm_pkg::CH0_PW_OFS, 32'h100);
        rd(dsm_pkg::CH0_PW_OFS, 32'h0, 1'b0);
        dir_in <= 2'b01;
        cyc(6);
        cmp_pin(sw, 2'b01);
        dir_in <= 2'b00;
        wr(dsm_pkg::SERIAL_OFS, 32'h8000);
        wr(dsm_pkg::SERIAL_OFS, 32'h0);
        wait_mode(dsm_pkg::DSM_NORMAL, 10);
        cyc(3);
        cmp_pin({1'b0, fs_oe_n}, 2'h1);
        wr(dsm_pkg::GCR_OFS, 32'h12);
        cyc(80);
        cmp_pin(mode, dsm_pkg::DSM_NORMAL);
        foreach (flt[i]) begin
            flt <= 8'h1 << i;
            wait_mode(dsm_pkg::DSM_FAULT, 10);
            cyc(2);
            cmp_pin(sw, 2'b00);
            flt <= 8'h0;
            wait_mode(dsm_pkg::DSM_NORMAL, 10);
        end
        for (int i = 0; i < 6; i++) begin
            wr(dsm_pkg::CH0_PW_OFS,
               {20'h0, 12'(72'h000000400B00BFF100 >> 12 * i)});
            dir_in <= {1'b0, i > 2 && i < 5};
            cyc(6);
            cmp_pin({1'b0, sw[0]}, {1'b0, 1'(6'h0B >> i)});
        end
        ext_run <= 1'b1;
        wr(dsm_pkg::CH1_PW_OFS, 32'h302);
        cyc(600);
        cmp_pin({1'b0, sw[1]}, 2'h1);
        ext_run <= 1'b0;
        cyc(600);
        cmp_pin({1'b0, sw[1]}, 2'h0);
        wr(dsm_pkg::GCR_OFS, 32'h11);
        flt <= 8'h80;
        cyc(10);
        cmp_pin(mode, dsm_pkg::DSM_NORMAL);
        flt <= 8'h0;
        supply_ok <= 1'b0;
        wait_mode(dsm_pkg::DSM_FAILSAFE, 10);
        supply_ok <= 1'b1;
        wr(dsm_pkg::SERIAL_OFS, 32'h8000);
        wr(dsm_pkg::SERIAL_OFS, 32'h0);
        wait_mode(dsm_pkg::DSM_NORMAL, 10);
        dir_in <= 2'b01;
        cyc(3);
        wake_req <= 1'b0;
        dir_in <= 2'b00;
        cyc(20);
        cmp_pin(mode, dsm_pkg::DSM_NORMAL);
        wait_mode(dsm_pkg::DSM_SLEEP, 60);
        dir_in <= 2'b01;
        wait_mode(dsm_pkg::DSM_NORMAL, 10);
        cyc(25);
        cmp_pin(sw, 2'b01);
        dir_in <= 2'b00;
        cyc(5);
        cmp_pin(sw, 2'b00);
        complete_run();
    end
    initial begin
        cyc(20000);
        n_mismatch++;
        complete_run();
    end
endmodule
bind dsm_mode_ctrl dsm_mode_ctrl_props u_props (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_wake_reset_pin(i_wake_reset_pin),
    .i_overcurrent_fault(i_overcurrent_fault),
    .i_overtemperature_fault(i_overtemperature_fault),
    .i_severe_short_fault(i_severe_short_fault),
    .i_undervoltage_fault(i_undervoltage_fault), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_switch_output(o_switch_output),
    .o_failsafe_indicator_pin_oe_n(o_failsafe_indicator_pin_oe_n),
    .o_normal_mode_flag(o_normal_mode_flag), .o_mode(o_mode));
